// ===== rtl/drv_run_policy.sv
// drv_run_policy: run command decode, stop, reset and write policy
// assumes pins asynchronous, trip_i and register port on ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module drv_run_policy
    import drv_pkg::*;
#(
    parameter logic [7:0] STOP_DISP_CODE = 8'hE0
)(
    // clock, reset, enable
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // register port
    input  wire logic [AW-1:0] reg_addr_i,
    input  wire logic [DW-1:0] reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [DW-1:0] reg_rdata_o,
    // terminals
    input  wire logic          fwd_start_input_i,
    input  wire logic          rev_start_input_i,
    input  wire logic          fault_clear_input_i,
    input  wire logic          speed_or_current_sel_input_i,
    // operator keypad
    input  wire logic          kp_present_i,
    input  wire logic          kp_stop_key_i,
    input  wire logic          kp_ext_key_i,
    input  wire logic          kp_pu_key_i,
    input  wire logic          kp_reset_key_i,
    // protection
    input  wire logic          trip_i,
    // drive control
    output logic               run_fwd_o,
    output logic               run_rev_o,
    output logic               out_shutoff_o,
    output logic               thermal_clear_o,
    output logic               alarm_led_o,
    output logic               current_ref_sel_o,
    output logic               multi_speed_sel_o,
    output logic               range_10v_o,
    output logic      [7:0]    kp_display_o,
    output logic      [DW-1:0] carrier_o,
    output logic               irq_o
);

    typedef enum logic [2:0] {
        KS_IDLE = 3'b001,
        KS_STOP = 3'b010,
        KS_ARM  = 3'b100
    } drv_kstop_e;

    typedef struct packed {
        logic [DW-1:0] carrier;
        logic [DW-1:0] arange;
        logic [DW-1:0] infunc;
        logic [DW-1:0] rpol;
        logic [DW-1:0] wlock;
        logic [DW-1:0] opmode;
        logic [DW-1:0] mon;
        logic [DW-1:0] mspd;
        logic [DW-1:0] gen;
        logic [DW-1:0] prot;
        logic          sel_ext;
        drv_kstop_e    ks;
        logic          ks_ext;
        logic          disc;
        logic          kon_prev;
        logic          clr_prev;
        logic          rej;
        logic [IW-1:0] ists;
        logic [IW-1:0] imask;
        logic [DW-1:0] rdata;
        logic          fwd;
        logic          rev;
        logic          shut;
        logic          cur;
        logic          mspd_sel;
    } drv_state_s;

    drv_state_s    s_q;
    drv_state_s    s_d;
    drv_pin_if     p ();

    logic          running;
    logic          ext_mode;
    logic          clr_acc;
    logic          starts_off;
    logic          kstop_hit;
    logic          disc_ev;
    logic          run_ok;
    logic          gen_ok;
    logic          any_ok;
    logic          wr_ok;
    logic          wr_known;
    logic [IW-1:0] ev;
    logic [DW-1:0] rd_val;

    // =====================================================
    // pin synchroniser
    drv_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .pins_i    ({kp_reset_key_i, kp_pu_key_i, kp_ext_key_i,
                     kp_stop_key_i, kp_present_i,
                     speed_or_current_sel_input_i, fault_clear_input_i,
                     rev_start_input_i, fwd_start_input_i}),
        .p         (p.src)
    );

    assign p.infunc = s_q.infunc;

    // =====================================================
    // policy terms
    assign running    = s_q.fwd || s_q.rev;
    assign starts_off = !p.pin[P_FWD] && !p.pin[P_REV];
    assign ext_mode   = (s_q.opmode == MODE_EXT)
                     || (s_q.opmode == MODE_SW && s_q.sel_ext);
    assign clr_acc    = (p.pin[P_CLR]
                         && (pol_any_time(s_q.rpol) || trip_i))
                     || (p.pin[P_KRST] && !pol_any_time(s_q.rpol)
                         && trip_i);
    assign kstop_hit  = p.pin[P_KSTP]
                     && (pol_stop_all(s_q.rpol) || !ext_mode);
    assign disc_ev    = s_q.kon_prev && !p.pin[P_KON]
                     && pol_disc_stop(s_q.rpol);
    // no start edge needed: a held start runs once clear ends
    assign run_ok     = !clr_acc && !s_q.disc && !trip_i
                     && (s_q.ks == KS_IDLE);

    // =====================================================
    // write permission
    assign gen_ok = (s_q.wlock == LOCK_STOP && !running)
                 || (s_q.wlock == LOCK_RUN);
    assign any_ok = (s_q.wlock == LOCK_STOP)
                 || (s_q.wlock == LOCK_RUN);

    always_comb
    begin
        wr_ok    = 1'b0;
        wr_known = 1'b1;
        case (reg_addr_i)
            A_CARRIER:
                wr_ok = gen_ok && reg_wdata_i >= CAR_LO_MIN
                     && reg_wdata_i <= CAR_HI_MAX
                     && (!running || car_hi(reg_wdata_i)
                         == car_hi(s_q.carrier));
            A_ARANGE:
                wr_ok = gen_ok && reg_wdata_i <= RNG_10V;
            A_INFUNC:
                wr_ok = gen_ok && (reg_wdata_i == FN_SPD
                     || reg_wdata_i == FN_CUR
                     || reg_wdata_i == FN_SPD_B
                     || reg_wdata_i == FN_CUR_B);
            A_RPOL:
                wr_ok = gen_ok && pol_valid(reg_wdata_i);
            A_WLOCK:
                wr_ok = reg_wdata_i <= LOCK_RUN;
            A_OPMODE:
                wr_ok = !running && reg_wdata_i <= MODE_MAX
                     && reg_wdata_i != MODE_BAD;
            A_MON, A_MSPD:
                wr_ok = any_ok;
            A_GEN:
                wr_ok = gen_ok;
            A_PROT:
                wr_ok = gen_ok && !running;
            default:
            begin
                wr_ok    = 1'b0;
                wr_known = 1'b0;
            end
        endcase
    end

    // =====================================================
    // read mux
    always_comb
    begin
        case (reg_addr_i)
            A_CARRIER: rd_val = s_q.carrier;
            A_ARANGE:  rd_val = s_q.arange;
            A_INFUNC:  rd_val = s_q.infunc;
            A_RPOL:    rd_val = s_q.rpol;
            A_WLOCK:   rd_val = s_q.wlock;
            A_OPMODE:  rd_val = s_q.opmode;
            A_MON:     rd_val = s_q.mon;
            A_MSPD:    rd_val = s_q.mspd;
            A_GEN:     rd_val = s_q.gen;
            A_PROT:    rd_val = s_q.prot;
            A_STATUS:  rd_val = {7'h00, ext_mode, s_q.ks_ext,
                                 s_q.ks != KS_IDLE, s_q.disc, s_q.shut,
                                 s_q.rev, s_q.fwd, s_q.rej,
                                 s_q.sel_ext};
            A_ISTS:    rd_val = {12'h000, s_q.ists};
            A_IMASK:   rd_val = {12'h000, s_q.imask};
            default:   rd_val = 16'h0000;
        endcase
    end

    // =====================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        ev  = '0;
        if (ce_i)
        begin
            // register writes
            if (reg_wr_i && wr_known)
            begin
                s_d.rej  = !wr_ok;
                ev[I_REJ] = !wr_ok;
            end
            if (reg_wr_i && wr_ok)
            begin
                case (reg_addr_i)
                    A_CARRIER: s_d.carrier = reg_wdata_i;
                    A_ARANGE:  s_d.arange  = reg_wdata_i;
                    A_INFUNC:  s_d.infunc  = reg_wdata_i;
                    A_RPOL:    s_d.rpol    = reg_wdata_i;
                    A_WLOCK:   s_d.wlock   = reg_wdata_i;
                    A_OPMODE:  s_d.opmode  = reg_wdata_i;
                    A_MON:     s_d.mon     = reg_wdata_i;
                    A_MSPD:    s_d.mspd    = reg_wdata_i;
                    A_GEN:     s_d.gen     = reg_wdata_i;
                    A_PROT:    s_d.prot    = reg_wdata_i;
                    default:   s_d.rej     = s_q.rej;
                endcase
            end
            if (reg_wr_i && reg_addr_i == A_IMASK)
                s_d.imask = reg_wdata_i[IW-1:0];
            if (reg_rd_i)
                s_d.rdata = rd_val;

            // keypad mode keys
            if (s_q.opmode == MODE_SW && p.pin[P_KEXT])
                s_d.sel_ext = 1'b1;
            else if (s_q.opmode == MODE_SW && p.pin[P_KPU])
                s_d.sel_ext = 1'b0;

            // keypad stop sequence
            case (s_q.ks)
                KS_IDLE:
                    if (kstop_hit && running)
                    begin
                        s_d.ks      = KS_STOP;
                        s_d.ks_ext  = ext_mode;
                        ev[I_KSTP]  = 1'b1;
                    end
                KS_STOP:
                    if (starts_off)
                        s_d.ks = s_q.ks_ext ? KS_ARM : KS_IDLE;
                KS_ARM:
                    if (!starts_off)
                        s_d.ks = KS_STOP;
                    else if (p.pin[P_KEXT])
                        s_d.ks = KS_IDLE;
                default:
                    s_d.ks = KS_IDLE;
            endcase
            if (clr_acc)
                s_d.ks = KS_IDLE;
            if (s_d.ks == KS_IDLE)
                s_d.ks_ext = 1'b0;

            // keypad disconnect alarm, set wins over clear
            s_d.kon_prev = p.pin[P_KON];
            if (clr_acc)
                s_d.disc = 1'b0;
            if (disc_ev)
                s_d.disc = 1'b1;
            ev[I_DISC] = disc_ev && !s_q.disc;

            // fault clear and outputs
            s_d.clr_prev = clr_acc;
            ev[I_CLR]    = clr_acc && !s_q.clr_prev;
            s_d.shut     = clr_acc || s_d.disc || trip_i;
            s_d.fwd      = p.dir_fwd && run_ok;
            s_d.rev      = p.dir_rev && run_ok;
            s_d.cur      = p.cur_sel;
            s_d.mspd_sel = !fn_cur(s_q.infunc) && p.pin[P_SEL];

            // interrupt status, read clears, set wins
            if (reg_rd_i && reg_addr_i == A_ISTS)
                s_d.ists = '0;
            s_d.ists = s_d.ists | ev;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q         <= '0;
            s_q.carrier <= RST_CARRIER;
            s_q.arange  <= RST_ARANGE;
            s_q.infunc  <= RST_INFUNC;
            s_q.rpol    <= RST_RPOL;
            s_q.wlock   <= RST_WLOCK;
            s_q.opmode  <= RST_OPMODE;
            s_q.ks      <= KS_IDLE;
        end
        else
            s_q <= s_d;
    end

    // =====================================================
    // outputs
    assign reg_rdata_o       = s_q.rdata;
    assign run_fwd_o         = s_q.fwd;
    assign run_rev_o         = s_q.rev;
    assign out_shutoff_o     = s_q.shut;
    assign thermal_clear_o   = s_q.clr_prev;
    assign alarm_led_o       = s_q.disc;
    assign current_ref_sel_o = s_q.cur;
    assign multi_speed_sel_o = s_q.mspd_sel;
    assign range_10v_o       = s_q.arange[0];
    assign carrier_o         = s_q.carrier;
    assign kp_display_o      = s_q.ks_ext ? STOP_DISP_CODE : 8'h00;
    assign irq_o             = |(s_q.ists & s_q.imask);

    // =====================================================
    // assertions
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    stop_both_a: assert property (
        ce_i && p.pin[P_FWD] && p.pin[P_REV] && !s_q.infunc[6]
        |=> !run_fwd_o && !run_rev_o)
        else $error("both starts did not stop the drive");

    rev_both_a: assert property (
        ce_i && p.pin[P_FWD] && p.pin[P_REV] && run_ok
        && (s_q.infunc == FN_SPD_B || s_q.infunc == FN_CUR_B)
        |=> run_rev_o && !run_fwd_o)
        else $error("both starts did not run reverse");

    car_band_a: assert property (
        ce_i && reg_wr_i && reg_addr_i == A_CARRIER && running
        && car_hi(reg_wdata_i) != car_hi(s_q.carrier)
        |=> $stable(carrier_o))
        else $error("carrier changed band while running");

    lock_gen_a: assert property (
        ce_i && reg_wr_i && reg_addr_i == A_GEN
        && s_q.wlock == LOCK_NONE
        |=> $stable(s_q.gen) && s_q.ists[I_REJ])
        else $error("locked write was taken");

    opmode_run_a: assert property (
        ce_i && reg_wr_i && reg_addr_i == A_OPMODE && running
        |=> $stable(s_q.opmode))
        else $error("mode written while running");

    clear_shut_a: assert property (
        ce_i && clr_acc |=> out_shutoff_o && thermal_clear_o
        && !run_fwd_o && !run_rev_o)
        else $error("held fault clear did not shut off");

    trip_only_a: assert property (
        ce_i && !trip_i && !pol_any_time(s_q.rpol) && !s_q.disc
        |=> !thermal_clear_o)
        else $error("fault clear taken without trip");

    disc_alarm_a: assert property (
        ce_i && disc_ev ##1 !clr_acc[*2]
        |-> alarm_led_o && out_shutoff_o)
        else $error("disconnect did not alarm");

    stop_disp_a: assert property (
        ce_i && s_q.ks == KS_IDLE && kstop_hit && running && ext_mode
        && !clr_acc |=> kp_display_o == STOP_DISP_CODE)
        else $error("stop code not shown");

    run_fwd_c: cover property ($rose(run_fwd_o));
    ks_arm_c:  cover property (s_q.ks == KS_ARM ##1 s_q.ks == KS_IDLE);
    reject_c:  cover property (s_q.rej && irq_o);

endmodule : drv_run_policy
`default_nettype wire

// ===== rtl/drv_pkg.sv
// drv_pkg: constants, register map and setting codes of the run policy
// assumes one clock domain and a plain address/strobe register port
// Contract
// - carrier setting resets to 1.0 kHz, the normal-noise point.
// - while running, carrier writes must stay inside their current band.
// - analog range code 0 is 0-5 V (default), code 1 is 0-10 V.
// - input function 0/100 gives speed select, 1/101 gives current select.
// - codes 0/1: fwd alone forward, rev alone reverse, else stop.
// - codes 100/101: fwd alone forward, both reverse, else stop.
// - current reference used only while the dual terminal is shorted.
// - reset policy sets when fault clear is accepted; keypad only trip-only.
// - policies 2,3,16,17 alarm and shut off on keypad disconnect.
// - policies 14-17 stop key works always; 0-3 not in external mode.
// - held fault clear shuts output, clears thermal data, motor coasts.
// - keypad stop in external mode shows the stop indication code.
// - start still active after fault clear runs the drive at once.
// - write lock 0 allows writes when stopped; lock 1 rejects writes.
// - under lock 0 monitor and multi-speed settings are always writable.
// - lock and operation-mode settings stay writable under any lock.
// - operation mode and protected settings reject writes while running.
package drv_pkg;

    localparam int DW = 16;
    localparam int AW = 8;
    localparam int IW = 4;
    localparam int NP = 9;

    // register offsets
    localparam logic [AW-1:0] A_CARRIER = 8'h00;
    localparam logic [AW-1:0] A_ARANGE  = 8'h04;
    localparam logic [AW-1:0] A_INFUNC  = 8'h08;
    localparam logic [AW-1:0] A_RPOL    = 8'h0C;
    localparam logic [AW-1:0] A_WLOCK   = 8'h10;
    localparam logic [AW-1:0] A_OPMODE  = 8'h14;
    localparam logic [AW-1:0] A_MON     = 8'h18;
    localparam logic [AW-1:0] A_MSPD    = 8'h1C;
    localparam logic [AW-1:0] A_GEN     = 8'h20;
    localparam logic [AW-1:0] A_PROT    = 8'h24;
    localparam logic [AW-1:0] A_STATUS  = 8'h28;
    localparam logic [AW-1:0] A_ISTS    = 8'h2C;
    localparam logic [AW-1:0] A_IMASK   = 8'h30;

    // reset values, carrier in 0.1 kHz steps
    localparam logic [DW-1:0] RST_CARRIER = 16'h000A;
    localparam logic [DW-1:0] RST_ARANGE  = 16'h0000;
    localparam logic [DW-1:0] RST_INFUNC  = 16'h0000;
    localparam logic [DW-1:0] RST_RPOL    = 16'h000E;
    localparam logic [DW-1:0] RST_WLOCK   = 16'h0000;
    localparam logic [DW-1:0] RST_OPMODE  = 16'h0000;

    // carrier bands
    localparam logic [DW-1:0] CAR_LO_MIN = 16'h0007;
    localparam logic [DW-1:0] CAR_LO_MAX = 16'h000B;
    localparam logic [DW-1:0] CAR_HI_MAX = 16'h0091;

    // codes
    localparam logic [DW-1:0] RNG_10V    = 16'h0001;
    localparam logic [DW-1:0] FN_SPD     = 16'h0000;
    localparam logic [DW-1:0] FN_CUR     = 16'h0001;
    localparam logic [DW-1:0] FN_SPD_B   = 16'h0064;
    localparam logic [DW-1:0] FN_CUR_B   = 16'h0065;
    localparam logic [DW-1:0] LOCK_STOP  = 16'h0000;
    localparam logic [DW-1:0] LOCK_NONE  = 16'h0001;
    localparam logic [DW-1:0] LOCK_RUN   = 16'h0002;
    localparam logic [DW-1:0] MODE_SW    = 16'h0000;
    localparam logic [DW-1:0] MODE_EXT   = 16'h0002;
    localparam logic [DW-1:0] MODE_BAD   = 16'h0005;
    localparam logic [DW-1:0] MODE_MAX   = 16'h0008;

    // pin vector positions
    localparam int P_FWD  = 0;
    localparam int P_REV  = 1;
    localparam int P_CLR  = 2;
    localparam int P_SEL  = 3;
    localparam int P_KON  = 4;
    localparam int P_KSTP = 5;
    localparam int P_KEXT = 6;
    localparam int P_KPU  = 7;
    localparam int P_KRST = 8;

    // interrupt bit positions
    localparam int I_REJ  = 0;
    localparam int I_KSTP = 1;
    localparam int I_DISC = 2;
    localparam int I_CLR  = 3;

    function automatic logic pol_valid(input logic [DW-1:0] c);
        pol_valid = (c <= 16'h0003) || (c >= 16'h000E && c <= 16'h0011);
    endfunction : pol_valid

    function automatic logic pol_any_time(input logic [DW-1:0] c);
        pol_any_time = !c[0];
    endfunction : pol_any_time

    function automatic logic pol_disc_stop(input logic [DW-1:0] c);
        pol_disc_stop = (c[1] && !c[3]) || c[4];
    endfunction : pol_disc_stop

    function automatic logic pol_stop_all(input logic [DW-1:0] c);
        pol_stop_all = c[3] || c[4];
    endfunction : pol_stop_all

    function automatic logic car_hi(input logic [DW-1:0] c);
        car_hi = c > CAR_LO_MAX;
    endfunction : car_hi

    function automatic logic fn_cur(input logic [DW-1:0] c);
        fn_cur = (c == FN_CUR) || (c == FN_CUR_B);
    endfunction : fn_cur

endpackage : drv_pkg

// ===== rtl/drv_pin_if.sv
// drv_pin_if: synchronised pins and decoded run direction
// assumes both ends on ref_clk_i
`timescale 1ns/10ps
`default_nettype none
interface drv_pin_if
    import drv_pkg::*;
;
    logic [NP-1:0] pin;
    logic [DW-1:0] infunc;
    logic          dir_fwd;
    logic          dir_rev;
    logic          cur_sel;

    modport src (output pin, dir_fwd, dir_rev, cur_sel, input infunc);
    modport dst (input pin, dir_fwd, dir_rev, cur_sel, output infunc);
endinterface : drv_pin_if
`default_nettype wire

// ===== rtl/drv_pin_sync.sv
// drv_pin_sync: two-stage pin synchroniser and start terminal decode
// assumes raw pins are asynchronous, active high when shorted to common
`timescale 1ns/10ps
`default_nettype none
module drv_pin_sync
    import drv_pkg::*;
(
    // clock, reset, enable
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // raw pins
    input  wire logic [NP-1:0] pins_i,
    // to policy logic
    drv_pin_if.src             p
);

    typedef struct packed {
        logic [NP-1:0] s1;
        logic [NP-1:0] s2;
    } drv_sync_s;

    drv_sync_s s_q;
    drv_sync_s s_d;
    logic      f;
    logic      r;

    // =====================================================
    // synchroniser
    always_comb
    begin
        s_d = s_q;
        if (ce_i)
        begin
            s_d.s1 = pins_i;
            s_d.s2 = s_q.s1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // =====================================================
    // direction decode
    assign f      = s_q.s2[P_FWD];
    assign r      = s_q.s2[P_REV];
    assign p.pin  = s_q.s2;

    always_comb
    begin
        p.dir_fwd = 1'b0;
        p.dir_rev = 1'b0;
        case (p.infunc)
            FN_SPD, FN_CUR:
            begin
                p.dir_fwd = f && !r;
                p.dir_rev = !f && r;
            end
            FN_SPD_B, FN_CUR_B:
            begin
                p.dir_fwd = f && !r;
                p.dir_rev = f && r;
            end
            default:
            begin
                p.dir_fwd = 1'b0;
                p.dir_rev = 1'b0;
            end
        endcase
    end

    assign p.cur_sel = fn_cur(p.infunc) && s_q.s2[P_SEL];

endmodule : drv_pin_sync
`default_nettype wire

// ===== testbench/drv_far_model.sv
// drv_far_model: start switches and operator keypad levels
// assumes levels change just after ref_clk_i rises
`timescale 1ns/10ps
`default_nettype none
module drv_far_model
    import drv_pkg::*;
(
    // clock
    input  wire logic          ref_clk_i,
    // terminal and keypad levels
    output logic      [NP-1:0] pins_o
);
    initial pins_o = '0;
    // switch levels are held until the next change
    task automatic set(input logic [NP-1:0] v);
        @(posedge ref_clk_i);
        pins_o <= v;
    endtask : set
endmodule : drv_far_model
`default_nettype wire

// ===== testbench/drv_run_policy_tb.sv
// drv_run_policy_tb: self-checking bench of the run policy
// assumes drv_pkg and the far-side model are compiled first
`timescale 1ns/10ps
`default_nettype none
module drv_run_policy_tb;
    import drv_pkg::*;
    logic          ref_clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic [AW-1:0] a = '0;
    logic [DW-1:0] wd = '0;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic [DW-1:0] rdat, car, d;
    logic [NP-1:0] p;
    logic          rf, rr, sh, th, cs, r10, irq, ms, al;
    logic [7:0]    kd;
    logic          tr = 1'b0;
    int            n_fail = 0;
    int            tests_run = 0;
    // =====================================================
    // clock, far side and block
    always #4 ref_clk_i = ~ref_clk_i;
    drv_far_model far (.ref_clk_i(ref_clk_i), .pins_o(p));
    drv_run_policy #(.STOP_DISP_CODE(8'hC3)) DUT (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .ce_i(1'b1),
        .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .fwd_start_input_i(p[P_FWD]),
        .rev_start_input_i(p[P_REV]), .fault_clear_input_i(p[P_CLR]),
        .speed_or_current_sel_input_i(p[P_SEL]), .kp_present_i(p[P_KON]),
        .kp_stop_key_i(p[P_KSTP]), .kp_ext_key_i(p[P_KEXT]),
        .kp_pu_key_i(p[P_KPU]), .kp_reset_key_i(p[P_KRST]), .trip_i(tr),
        .run_fwd_o(rf), .run_rev_o(rr), .out_shutoff_o(sh),
        .thermal_clear_o(th), .alarm_led_o(al), .current_ref_sel_o(cs),
        .multi_speed_sel_o(ms), .range_10v_o(r10), .kp_display_o(kd),
        .carrier_o(car), .irq_o(irq));
    // =====================================================
    // bus, pins and checks
    task automatic w(input logic [AW-1:0] ad, input logic [DW-1:0] v);
        @(posedge ref_clk_i);
        a <= ad; wd <= v; wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask : w
    task automatic r(input logic [AW-1:0] ad);
        @(posedge ref_clk_i);
        a <= ad; rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        @(negedge ref_clk_i);
        d = rdat;
    endtask : r
    task automatic pin(input logic [NP-1:0] v);
        far.set(v);
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask : pin
    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // =====================================================
    // scenarios
    task automatic t_reset;
        r(A_CARRIER); chk(d, RST_CARRIER);
        chk(car, RST_CARRIER);
        r(A_ARANGE); chk(d, RST_ARANGE);
        r(A_RPOL); chk(d, RST_RPOL);
        w(A_ARANGE, RNG_10V); @(negedge ref_clk_i); chk(r10, 1'b1);
    endtask : t_reset
    task automatic t_dir;
        logic [DW-1:0] f;
        for (int k = 0; k < 2; k++)
        begin
            f = k ? FN_CUR_B : FN_SPD;
            w(A_INFUNC, f);
            for (int i = 0; i < 4; i++)
            begin
                pin(NP'(i));
                chk(rf, i == 1);
                chk(rr, k ? i == 3 : i == 2);
            end
        end
        pin(9'h008); chk(cs, 1'b1);
        pin(9'h000);
    endtask : t_dir
    task automatic t_run;
        w(A_WLOCK, LOCK_RUN); w(A_INFUNC, FN_SPD); w(A_GEN, 16'h0003);
        pin(9'h001); chk(rf, 1'b1);
        w(A_CARRIER, 16'h000C); r(A_CARRIER); chk(d, 16'h000A);
        w(A_CARRIER, CAR_LO_MIN); r(A_CARRIER); chk(d, CAR_LO_MIN);
        w(A_IMASK, 16'h0001); w(A_OPMODE, MODE_EXT);
        r(A_OPMODE); chk(d, RST_OPMODE);
        chk(irq, 1'b1);
        r(A_ISTS); chk(d[I_REJ], 1'b1);
        repeat (2) @(negedge ref_clk_i);
        chk(irq, 1'b0);
        pin(9'h005); chk(sh, 1'b1); chk(th, 1'b1); chk(rf, 1'b0);
        pin(9'h001); chk(rf, 1'b1);
        pin(9'h000);
    endtask : t_run
    task automatic t_lock;
        w(A_WLOCK, LOCK_NONE); w(A_GEN, 16'h0005);
        r(A_GEN); chk(d, 16'h0003);
        w(A_WLOCK, LOCK_STOP); r(A_WLOCK); chk(d, LOCK_STOP);
        pin(9'h001);
        w(A_MSPD, 16'h0009); r(A_MSPD); chk(d, 16'h0009);
        w(A_GEN, 16'h0007); r(A_GEN); chk(d, 16'h0003);
        pin(9'h000);
    endtask : t_lock
    task automatic t_kp;
        pin(9'h048); chk(ms, 1'b1);
        pin(9'h001); chk(rf, 1'b1);
        pin(9'h021); chk(rf, 1'b0);
        chk(kd, 8'hC3);
        pin(9'h001); chk(rf, 1'b0);
        pin(9'h000); pin(9'h040);
        chk(kd, 8'h00);
        pin(9'h001); chk(rf, 1'b1);
        pin(9'h010); pin(9'h000);
        chk(al, 1'b0);
        w(A_RPOL, 16'h0010); pin(9'h010); pin(9'h000);
        chk(al, 1'b1);
        chk(sh, 1'b1);
        pin(9'h001); chk(rf, 1'b0);
        pin(9'h004); chk(al, 1'b0);
        w(A_RPOL, 16'h000F); pin(9'h004);
        chk(th, 1'b0);
        @(posedge ref_clk_i);
        tr <= 1'b1;
        pin(9'h004); chk(th, 1'b1);
        @(posedge ref_clk_i);
        tr <= 1'b0;
        pin(9'h000);
    endtask : t_kp
    // =====================================================
    // main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset(); t_dir(); t_run(); t_lock(); t_kp();
        stop_test();
    end
    initial
    begin
        #400000;
        n_fail++;
        stop_test();
    end
endmodule : drv_run_policy_tb
`default_nettype wire
